// ### mou_pkg.sv
`default_nettype none
package mou_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int BE_W   = 8;
   localparam int MASK_W = 7;
   localparam int RD_W   = 5;
   localparam int CNT_W  = 3;
   localparam int LO_W   = 3;

   // Barrier constraint bit positions
   localparam int BAR_LOAD_LOAD   = 0;
   localparam int BAR_STORE_LOAD  = 1;
   localparam int BAR_LOAD_STORE  = 2;
   localparam int BAR_STORE_STORE = 3;
   localparam int BAR_LOOKASIDE   = 4;
   localparam int BAR_MEM_ISSUE   = 5;
   localparam int BAR_SYNC        = 6;

   localparam logic [CNT_W-1:0]  MAX_OUTSTANDING = 3'h4;
   localparam logic [CNT_W-1:0]  CNT_ZERO        = 3'h0;
   localparam logic [CNT_W-1:0]  CNT_ONE         = 3'h1;
   localparam logic [MASK_W-1:0] MASK_ZERO       = 7'h00;
   localparam logic [BE_W-1:0]   BE_NONE         = 8'h00;
   localparam logic [BE_W-1:0]   BE_BYTE         = 8'h01;
   localparam logic [BE_W-1:0]   BE_WORD         = 8'h0F;
   localparam logic [BE_W-1:0]   BE_DWORD        = 8'hFF;
   localparam logic [DATA_W-1:0] DATA_ZERO       = 64'h0000_0000_0000_0000;
   localparam logic [DATA_W-1:0] BYTE_ONES       = 64'h0000_0000_0000_00FF;
   localparam logic [LO_W-1:0]   LO_ZERO         = 3'h0;

   typedef enum logic [2:0] {
      OP_LOAD, OP_STORE, OP_BYTE_SET, OP_SWAP, OP_CAS, OP_BARRIER, OP_FLUSH
   } mou_op_t;

   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} mou_size_t;

   typedef enum logic [1:0] {
      TOTAL_STORE_ORDER, PARTIAL_STORE_ORDER, RELAXED_MEMORY_ORDER
   } mou_model_t;

   typedef enum logic [1:0] {MC_READ, MC_WRITE, MC_FLUSH} mou_cmd_t;

   typedef struct packed {
      mou_op_t             op;
      mou_size_t           size;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [DATA_W-1:0]   cmp;
      logic [MASK_W-1:0]   mask;
      logic [RD_W-1:0]     rd;
   } mou_req_t;

   typedef struct packed {
      mou_cmd_t            cmd;
      logic                lock;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [BE_W-1:0]     be;
   } mou_mreq_t;

   typedef struct packed {
      logic [RD_W-1:0]     rd;
      logic [DATA_W-1:0]   data;
   } mou_rsp_t;

   function automatic logic [BE_W-1:0] lane_be(input mou_size_t sz, input logic [LO_W-1:0] lo);
      case (sz)
         SZ_BYTE: lane_be = BE_BYTE << lo;
         SZ_WORD: lane_be = BE_WORD << {lo[2], 2'b00};
         default: lane_be = BE_DWORD;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] lane_get(input logic [DATA_W-1:0] d,
                                                  input mou_size_t sz,
                                                  input logic [LO_W-1:0] lo);
      logic [DATA_W-1:0] s;
      s = DATA_ZERO;
      case (sz)
         SZ_BYTE: begin
            s = d >> {lo, 3'b000};
            lane_get = DATA_W'(s[7:0]);
         end
         SZ_WORD: begin
            s = d >> {lo[2], 5'b00000};
            lane_get = DATA_W'(s[31:0]);
         end
         default: lane_get = d;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] lane_put(input logic [DATA_W-1:0] v,
                                                  input mou_size_t sz,
                                                  input logic [LO_W-1:0] lo);
      case (sz)
         SZ_BYTE: lane_put = DATA_W'(v[7:0]) << {lo, 3'b000};
         SZ_WORD: lane_put = DATA_W'(v[31:0]) << {lo[2], 5'b00000};
         default: lane_put = v;
      endcase
   endfunction
endpackage
`default_nettype wire

// ### mou_amo.sv
`default_nettype none
module mou_amo
   import mou_pkg::*;
(
   input  wire mou_pkg::mou_op_t              op_in,
   input  wire mou_pkg::mou_size_t            size_in,
   input  wire logic [mou_pkg::LO_W-1:0]      lo_in,
   input  wire logic [mou_pkg::DATA_W-1:0]    old_dw_in,
   input  wire logic [mou_pkg::DATA_W-1:0]    wdata_in,
   input  wire logic [mou_pkg::DATA_W-1:0]    cmp_in,
   output logic      [mou_pkg::DATA_W-1:0]    old_val_out,
   output logic      [mou_pkg::DATA_W-1:0]    new_dw_out,
   output logic      [mou_pkg::BE_W-1:0]      be_out
);
   mou_size_t sz;
   logic      match;

   always_comb begin
      sz          = (op_in == OP_BYTE_SET) ? SZ_BYTE : size_in;
      old_val_out = lane_get(old_dw_in, sz, lo_in);
      match       = (old_val_out == lane_get(cmp_in, sz, LO_ZERO));
      new_dw_out  = lane_put(wdata_in, sz, lo_in);
      be_out      = lane_be(sz, lo_in);
      case (op_in)
         OP_BYTE_SET: begin
            new_dw_out = lane_put(BYTE_ONES, SZ_BYTE, lo_in);
         end
         OP_SWAP: begin
            be_out = lane_be(sz, lo_in);
         end
         OP_CAS: begin
            be_out = match ? lane_be(sz, lo_in) : BE_NONE;
         end
         default: begin
            be_out = lane_be(sz, lo_in);
         end
      endcase
   end
endmodule
`default_nettype wire

// ### mou_ordr.sv
`default_nettype none
module mou_ordr
   import mou_pkg::*;
(
   input  wire logic                          clk_in,
   input  wire logic                          rst_in,
   input  wire mou_pkg::mou_model_t           model_in,
   input  wire logic                          issue_in,
   input  wire logic                          ack_in,
   input  wire logic                          bar_set_in,
   input  wire logic [mou_pkg::MASK_W-1:0]    bar_mask_in,
   output logic      [mou_pkg::CNT_W-1:0]     count_out,
   output logic      [mou_pkg::MASK_W-1:0]    pend_out,
   output logic                               store_block_out,
   output logic                               drained_out
);
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic [MASK_W-1:0] pend_q;
   logic [MASK_W-1:0] pend_d;
   logic              order_stores;

   always_comb begin
      cnt_d = cnt_q;
      if (issue_in && !ack_in) begin
         cnt_d = cnt_q + CNT_ONE;
      end else if (ack_in && !issue_in && cnt_q != CNT_ZERO) begin
         cnt_d = cnt_q - CNT_ONE;
      end
      // A satisfied constraint retires once the stores drain; a new barrier wins
      pend_d = (cnt_q == CNT_ZERO) ? MASK_ZERO : pend_q;
      if (bar_set_in) begin
         pend_d = pend_d | bar_mask_in;
      end
      order_stores = (model_in == TOTAL_STORE_ORDER)
                   | pend_q[BAR_STORE_STORE]
                   | pend_q[BAR_MEM_ISSUE]
                   | pend_q[BAR_SYNC];
      store_block_out = (order_stores && cnt_q != CNT_ZERO)
                      || (cnt_q == MAX_OUTSTANDING);
      drained_out     = (cnt_q == CNT_ZERO);
      count_out       = cnt_q;
      pend_out        = pend_q;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_q  <= CNT_ZERO;
         pend_q <= MASK_ZERO;
      end else begin
         cnt_q  <= cnt_d;
         pend_q <= pend_d;
      end
   end
endmodule
`default_nettype wire

// ### mou_top.sv
`default_nettype none
module mou_top
   import mou_pkg::*;
(
   input  wire logic                          CORE_CLK_IN,
   input  wire logic                          RESET_IN,
   input  wire mou_pkg::mou_model_t           MODEL_IN,
   input  wire logic                          REQ_VALID_IN,
   input  wire mou_pkg::mou_req_t             REQ_IN,
   output logic                               REQ_READY_OUT,
   output logic                               RSP_VALID_OUT,
   output mou_pkg::mou_rsp_t                  RSP_OUT,
   output logic                               MEM_REQ_VALID_OUT,
   output mou_pkg::mou_mreq_t                 MEM_REQ_OUT,
   input  wire logic                          MEM_REQ_READY_IN,
   input  wire logic                          MEM_RDATA_VALID_IN,
   input  wire logic [mou_pkg::DATA_W-1:0]    MEM_RDATA_IN,
   input  wire logic                          MEM_WACK_IN,
   input  wire logic                          MEM_FACK_IN,
   output logic [mou_pkg::CNT_W-1:0]          OUTSTANDING_OUT
);
   typedef enum logic [2:0] {
      S_IDLE, S_ORDER, S_ISSUE, S_RDWAIT, S_AMOWR, S_AMOACK, S_FLUSHW
   } mou_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // State
   mou_state_t        state_q;
   mou_state_t        state_d;
   mou_req_t          req_q;
   mou_req_t          req_d;
   logic              ready_q;
   logic              ready_d;
   logic              rsp_valid_q;
   logic              rsp_valid_d;
   mou_rsp_t          rsp_q;
   mou_rsp_t          rsp_d;
   logic              mvalid_q;
   logic              mvalid_d;
   mou_mreq_t         mreq_q;
   mou_mreq_t         mreq_d;
   logic [DATA_W-1:0] old_q;
   logic [DATA_W-1:0] old_d;
   logic [CNT_W-1:0]  outst_q;

   logic              issue;
   logic              bar_set;
   logic              store_block;
   logic              drained;
   logic [CNT_W-1:0]  count;
   logic [DATA_W-1:0] amo_old;
   logic [DATA_W-1:0] amo_new;
   logic [BE_W-1:0]   amo_be;
   logic              is_atomic;
   logic              accepted;

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   mou_ordr u_ordr (
      .clk_in          (CORE_CLK_IN),
      .rst_in          (RESET_IN),
      .model_in        (MODEL_IN),
      .issue_in        (issue),
      .ack_in          (MEM_WACK_IN),
      .bar_set_in      (bar_set),
      .bar_mask_in     (REQ_IN.mask),
      .count_out       (count),
      .pend_out        (),
      .store_block_out (store_block),
      .drained_out     (drained)
   );

   mou_amo u_amo (
      .op_in       (req_q.op),
      .size_in     (req_q.size),
      .lo_in       (req_q.addr[LO_W-1:0]),
      .old_dw_in   (MEM_RDATA_IN),
      .wdata_in    (req_q.wdata),
      .cmp_in      (req_q.cmp),
      .old_val_out (amo_old),
      .new_dw_out  (amo_new),
      .be_out      (amo_be)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      state_d     = state_q;
      req_d       = req_q;
      ready_d     = ready_q;
      rsp_valid_d = 1'b0;
      rsp_d       = rsp_q;
      mvalid_d    = mvalid_q;
      mreq_d      = mreq_q;
      old_d       = old_q;
      issue       = 1'b0;
      bar_set     = 1'b0;
      accepted    = mvalid_q && MEM_REQ_READY_IN;
      is_atomic   = (req_q.op == OP_BYTE_SET) || (req_q.op == OP_SWAP)
                 || (req_q.op == OP_CAS);
      case (state_q)
         S_IDLE: begin
            if (REQ_VALID_IN && ready_q) begin
               req_d   = REQ_IN;
               ready_d = 1'b0;
               if (REQ_IN.op == OP_BARRIER) begin
                  bar_set     = 1'b1;
                  rsp_valid_d = 1'b1;
                  rsp_d       = '{rd: REQ_IN.rd, data: DATA_ZERO};
                  ready_d     = 1'b1;
               end else begin
                  state_d = S_ORDER;
               end
            end
         end
         S_ORDER: begin
            mreq_d.addr  = req_q.addr;
            mreq_d.lock  = 1'b0;
            mreq_d.wdata = lane_put(req_q.wdata, req_q.size, req_q.addr[LO_W-1:0]);
            mreq_d.be    = lane_be(req_q.size, req_q.addr[LO_W-1:0]);
            case (req_q.op)
               OP_LOAD: begin
                  // Loads wait for all stores to drain, so no load sees stale data
                  if (drained) begin
                     mreq_d.cmd = MC_READ;
                     mvalid_d   = 1'b1;
                     state_d    = S_ISSUE;
                  end
               end
               OP_STORE: begin
                  if (!store_block) begin
                     mreq_d.cmd = MC_WRITE;
                     mvalid_d   = 1'b1;
                     state_d    = S_ISSUE;
                  end
               end
               OP_FLUSH: begin
                  if (drained) begin
                     mreq_d.cmd = MC_FLUSH;
                     mvalid_d   = 1'b1;
                     state_d    = S_ISSUE;
                  end
               end
               default: begin
                  if (drained) begin
                     mreq_d.cmd  = MC_READ;
                     mreq_d.lock = 1'b1;
                     mvalid_d    = 1'b1;
                     state_d     = S_ISSUE;
                  end
               end
            endcase
         end
         S_ISSUE: begin
            if (accepted) begin
               mvalid_d = 1'b0;
               case (req_q.op)
                  OP_STORE: begin
                     issue       = 1'b1;
                     rsp_valid_d = 1'b1;
                     rsp_d       = '{rd: req_q.rd, data: DATA_ZERO};
                     ready_d     = 1'b1;
                     state_d     = S_IDLE;
                  end
                  OP_FLUSH: begin
                     state_d = S_FLUSHW;
                  end
                  default: begin
                     state_d = S_RDWAIT;
                  end
               endcase
            end
         end
         S_RDWAIT: begin
            if (MEM_RDATA_VALID_IN) begin
               if (is_atomic) begin
                  old_d        = amo_old;
                  mreq_d.cmd   = MC_WRITE;
                  mreq_d.lock  = 1'b0;
                  mreq_d.wdata = amo_new;
                  mreq_d.be    = amo_be;
                  mvalid_d     = 1'b1;
                  state_d      = S_AMOWR;
               end else begin
                  rsp_valid_d = 1'b1;
                  rsp_d       = '{rd: req_q.rd,
                                  data: lane_get(MEM_RDATA_IN, req_q.size,
                                                 req_q.addr[LO_W-1:0])};
                  ready_d     = 1'b1;
                  state_d     = S_IDLE;
               end
            end
         end
         S_AMOWR: begin
            if (accepted) begin
               mvalid_d = 1'b0;
               issue    = 1'b1;
               state_d  = S_AMOACK;
            end
         end
         S_AMOACK: begin
            if (drained) begin
               rsp_valid_d = 1'b1;
               rsp_d       = '{rd: req_q.rd, data: old_q};
               ready_d     = 1'b1;
               state_d     = S_IDLE;
            end
         end
         S_FLUSHW: begin
            if (MEM_FACK_IN) begin
               rsp_valid_d = 1'b1;
               rsp_d       = '{rd: req_q.rd, data: DATA_ZERO};
               ready_d     = 1'b1;
               state_d     = S_IDLE;
            end
         end
         default: begin
            state_d  = S_IDLE;
            ready_d  = 1'b1;
            mvalid_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         state_q     <= S_IDLE;
         req_q       <= '0;
         ready_q     <= 1'b1;
         rsp_valid_q <= 1'b0;
         rsp_q       <= '0;
         mvalid_q    <= 1'b0;
         mreq_q      <= '0;
         old_q       <= DATA_ZERO;
         outst_q     <= CNT_ZERO;
      end else begin
         state_q     <= state_d;
         req_q       <= req_d;
         ready_q     <= ready_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_q       <= rsp_d;
         mvalid_q    <= mvalid_d;
         mreq_q      <= mreq_d;
         old_q       <= old_d;
         outst_q     <= count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_comb begin
      REQ_READY_OUT     = ready_q;
      RSP_VALID_OUT     = rsp_valid_q;
      RSP_OUT           = rsp_q;
      MEM_REQ_VALID_OUT = mvalid_q;
      MEM_REQ_OUT       = mreq_q;
      OUTSTANDING_OUT   = outst_q;
   end
endmodule
`default_nettype wire

// ### mou_checker.sv
`default_nettype none
module mou_checker
   import mou_pkg::*;
(
   input wire logic                      CORE_CLK_IN,
   input wire logic                      RESET_IN,
   input wire mou_pkg::mou_model_t       MODEL_IN,
   input wire logic                      REQ_VALID_IN,
   input wire mou_pkg::mou_req_t         REQ_IN,
   input wire logic                      REQ_READY_OUT,
   input wire logic                      RSP_VALID_OUT,
   input wire mou_pkg::mou_rsp_t         RSP_OUT,
   input wire logic                      MEM_REQ_VALID_OUT,
   input wire mou_pkg::mou_mreq_t        MEM_REQ_OUT,
   input wire logic                      MEM_REQ_READY_IN,
   input wire logic [mou_pkg::CNT_W-1:0] OUTSTANDING_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RESET_IN);
   logic m_acc;
   logic take;
   assign m_acc = MEM_REQ_VALID_OUT && MEM_REQ_READY_IN;
   assign take = REQ_VALID_IN && REQ_READY_OUT;
   ////////////////////////////////////////////////////////////////////////////
   a_mreq_held: assert property (MEM_REQ_VALID_OUT && !MEM_REQ_READY_IN |=>
      MEM_REQ_VALID_OUT && $stable(MEM_REQ_OUT)) else $error("memory request moved");
   a_tso_single: assert property (MODEL_IN == TOTAL_STORE_ORDER |->
      OUTSTANDING_OUT <= CNT_ONE) else $error("several stores outstanding in total order");
   a_outst_max: assert property (OUTSTANDING_OUT <= MAX_OUTSTANDING)
      else $error("outstanding count above limit");
   a_busy_after_take: assert property (take && REQ_IN.op != OP_BARRIER |=>
      !REQ_READY_OUT) else $error("ready stayed high after a take");
   a_bar_answer: assert property (take && REQ_IN.op == OP_BARRIER |=> RSP_VALID_OUT &&
      RSP_OUT.rd == $past(REQ_IN.rd) && RSP_OUT.data == DATA_ZERO)
      else $error("barrier answer wrong");
   a_lock_is_read: assert property (MEM_REQ_VALID_OUT && MEM_REQ_OUT.lock |->
      MEM_REQ_OUT.cmd == MC_READ) else $error("lock on a non-read");
   a_lock_window: assert property (m_acc && MEM_REQ_OUT.lock |=>
      (!MEM_REQ_VALID_OUT || MEM_REQ_OUT.cmd == MC_WRITE) [*4])
      else $error("other access inside atomic");
   a_flush_done: assert property (m_acc && MEM_REQ_OUT.cmd == MC_FLUSH |->
      ##[1:20] RSP_VALID_OUT) else $error("flush not answered");
   a_load_answer: assert property (m_acc && MEM_REQ_OUT.cmd == MC_READ &&
      !MEM_REQ_OUT.lock |-> ##[1:30] RSP_VALID_OUT) else $error("load not answered");
   c_barrier: cover property (take && REQ_IN.op == OP_BARRIER);
   c_multi: cover property (OUTSTANDING_OUT > CNT_ONE);
   c_locked: cover property (m_acc && MEM_REQ_OUT.lock);
   c_flush: cover property (m_acc && MEM_REQ_OUT.cmd == MC_FLUSH);
endmodule
bind mou_top mou_checker mou_checker_i (.CORE_CLK_IN, .RESET_IN, .MODEL_IN, .REQ_VALID_IN,
   .REQ_IN, .REQ_READY_OUT, .RSP_VALID_OUT, .RSP_OUT, .MEM_REQ_VALID_OUT, .MEM_REQ_OUT,
   .MEM_REQ_READY_IN, .OUTSTANDING_OUT);
`default_nettype wire

// ### mou_mem_model.sv
`default_nettype none
module mou_mem_model
   import mou_pkg::*;
(
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     valid_in,
   input  wire mou_pkg::mou_mreq_t       mreq_in,
   output var logic                      ready_out,
   output var logic                      rvalid_out,
   output var logic [mou_pkg::DATA_W-1:0] rdata_out,
   output var logic                      wack_out,
   output var logic                      fack_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [16];
   logic [DATA_W-1:0] rbuf;
   logic [3:0]        ix;
   int                rwait;
   int                fwait;
   int                wpend;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = DATA_ZERO;
      rdata_out = DATA_ZERO;
      ready_out = 1'b0;
      rvalid_out = 1'b0;
      wack_out = 1'b0;
      fack_out = 1'b0;
   end
   always @(posedge clk_in) begin
      ix = mreq_in.addr[6:3];
      rvalid_out <= 1'b0;
      wack_out <= 1'b0;
      fack_out <= 1'b0;
      ready_out <= ($urandom % 4) != 0;
      // Idle read lines toggle so stale data never looks valid
      rdata_out <= ~rdata_out;
      if (rst_in) begin
         rwait = 0;
         fwait = 0;
         wpend = 0;
      end else begin
         if (rwait == 1) begin
            rvalid_out <= 1'b1;
            rdata_out <= rbuf;
         end
         if (rwait > 0) rwait--;
         if (fwait == 1) fack_out <= 1'b1;
         if (fwait > 0) fwait--;
         // Acks come slowly so several stores stay outstanding outside total store order
         if (wpend > 0 && $urandom % 3 == 0) begin
            wack_out <= 1'b1;
            wpend--;
         end
         if (valid_in && ready_out) begin
            // Single requester, so a locked location is never touched between halves
            case (mreq_in.cmd)
               MC_READ: begin
                  rbuf = mem[ix];
                  rwait = 1 + $urandom % 4;
               end
               MC_WRITE: begin
                  for (int b = 0; b < BE_W; b++)
                     if (mreq_in.be[b]) mem[ix][8*b +: 8] = mreq_in.wdata[8*b +: 8];
                  wpend++;
               end
               default: fwait = 3;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ### mou_top_bench.sv
`default_nettype none
module mou_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mou_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   mou_model_t        model = TOTAL_STORE_ORDER;
   logic              req_valid = 1'b0;
   mou_req_t          req = '0;
   logic              req_ready, rsp_valid, m_valid, m_ready, m_rvalid, m_wack, m_fack;
   mou_rsp_t          rsp;
   mou_mreq_t         mreq;
   logic [DATA_W-1:0] m_rdata;
   logic [CNT_W-1:0]  outst;
   logic [DATA_W-1:0] shadow [16];
   int                fail_count = 0;
   int                samples_checked = 0;
   int                cyc = 0;
   always #50 clk = ~clk;
   mou_top mou_top_i (.CORE_CLK_IN(clk), .RESET_IN(rst), .MODEL_IN(model),
      .REQ_VALID_IN(req_valid), .REQ_IN(req), .REQ_READY_OUT(req_ready),
      .RSP_VALID_OUT(rsp_valid), .RSP_OUT(rsp), .MEM_REQ_VALID_OUT(m_valid),
      .MEM_REQ_OUT(mreq), .MEM_REQ_READY_IN(m_ready), .MEM_RDATA_VALID_IN(m_rvalid),
      .MEM_RDATA_IN(m_rdata), .MEM_WACK_IN(m_wack), .MEM_FACK_IN(m_fack),
      .OUTSTANDING_OUT(outst));
   mou_mem_model mou_mem_model_i (.clk_in(clk), .rst_in(rst), .valid_in(m_valid),
      .mreq_in(mreq), .ready_out(m_ready), .rvalid_out(m_rvalid), .rdata_out(m_rdata),
      .wack_out(m_wack), .fack_out(m_fack));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   function automatic logic [DATA_W-1:0] wmask(input mou_size_t s);
      return s == SZ_BYTE ? 64'h0000_0000_0000_00ff :
             s == SZ_WORD ? 64'h0000_0000_ffff_ffff : '1;
   endfunction
   // One whole request: drive at a falling edge, hold until taken, await answer
   task automatic run(input mou_op_t op, input mou_size_t sz, input logic [3:0] ix,
         input logic [2:0] lo, input logic [DATA_W-1:0] wd, cmp, input bit hit);
      logic [DATA_W-1:0] m, old, c, d;
      int                sh, n;
      logic [4:0]        rd;
      rd = 5'($urandom);
      sh = sz == SZ_DWORD ? 0 : sz == SZ_WORD ? 32 * lo[2] : 8 * lo;
      m = wmask(sz);
      d = shadow[ix];
      old = (d >> sh) & m;
      c = hit ? old : cmp;
      if (op inside {OP_STORE, OP_BYTE_SET, OP_SWAP} || (op == OP_CAS && old == (c & m)))
         shadow[ix] = (d & ~(m << sh)) | (((op == OP_BYTE_SET) ? m : wd & m) << sh);
      if (!(op inside {OP_LOAD, OP_BYTE_SET, OP_SWAP, OP_CAS})) old = DATA_ZERO;
      req = '{op: op, size: sz, addr: {25'h000_0000, ix, lo}, wdata: wd, cmp: c,
              mask: 7'($urandom), rd: rd};
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      check("rsp_valid", 64'(rsp_valid), 64'h0000_0000_0000_0001);
      check("rsp.data", rsp.data, old);
      check("rsp.rd", 64'(rsp.rd), 64'(rd));
      // Let an edge pass so the next call never re-raises valid in this time step
      @(negedge clk);
   endtask
   initial begin
      mou_op_t   op;
      mou_size_t sz;
      logic [2:0] lo;
      for (int i = 0; i < 16; i++) shadow[i] = DATA_ZERO;
      void'($urandom(32'hbd66ab8c));
      for (int md = 0; md < 3; md++) begin
         @(negedge clk);
         rst = 1'b1;
         model = mou_model_t'(md);
         repeat (16) @(negedge clk);
         check("ready in reset", 64'({req_ready, rsp_valid, outst}), 64'h0000_0000_0000_0010);
         rst = 1'b0;
         run(OP_STORE, SZ_DWORD, 4'h2, 3'h0, 64'h0123_4567_89ab_cdef, DATA_ZERO, 0);
         run(OP_FLUSH, SZ_DWORD, 4'h2, 3'h0, DATA_ZERO, DATA_ZERO, 0);
         run(OP_BYTE_SET, SZ_BYTE, 4'h2, 3'h7, DATA_ZERO, DATA_ZERO, 0);
         run(OP_CAS, SZ_DWORD, 4'h2, 3'h0, 64'h0000_0000_0000_0005, DATA_ZERO, 0);
         run(OP_CAS, SZ_WORD, 4'h2, 3'h4, 64'h0000_0000_0bad_cafe, DATA_ZERO, 1);
         run(OP_SWAP, SZ_WORD, 4'h2, 3'h0, 64'h0000_0000_1357_9bdf, DATA_ZERO, 0);
         run(OP_BARRIER, SZ_DWORD, 4'h0, 3'h0, DATA_ZERO, DATA_ZERO, 0);
         run(OP_BARRIER, SZ_DWORD, 4'h0, 3'h0, DATA_ZERO, DATA_ZERO, 0);
         for (int k = 0; k < 6; k++)
            run(OP_STORE, SZ_DWORD, 4'(k + 8), 3'h0, {$urandom, $urandom}, DATA_ZERO, 0);
         run(OP_LOAD, SZ_DWORD, 4'h8, 3'h0, DATA_ZERO, DATA_ZERO, 0);
         for (int k = 0; k < 80; k++) begin
            op = mou_op_t'($urandom % 7);
            sz = op == OP_BYTE_SET ? SZ_BYTE : mou_size_t'($urandom % 3);
            lo = sz == SZ_BYTE ? 3'($urandom) : sz == SZ_WORD ? {1'($urandom), 2'b00} : 3'h0;
            run(op, sz, 4'($urandom), lo, {$urandom, $urandom}, {$urandom, $urandom},
                1'($urandom));
         end
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
